/* File: cgm_consts.svh */
// Summary of operation
// R01 - idle stops processor clock until interrupt or reset; peripherals keep own enables
// R02 - peripheral dma channel clock keeps running during idle
// R03 - after reset the block runs in slow-clock mode
// R04 - slow-clock mode keeps main oscillator and pll powered down; code powers down only the pll, the oscillator follows its enable bit
// R05 - standby is slow-clock mode plus stopped processor clock, woken by event
// R06 - low speed permanent clock is never switched off
// R07 - master clock always supplied to permanently running modules
// R08 - processor clock follows master clock, gated off in idle
// R09 - optional divide-by-two stage, presence fixed at build time
// R10 - main oscillator disabled when reset is released
// R11 - clearing oscillator enable stops oscillator and clears stable flag
// R12 - enable write clears stable, loads count, decrements per slow/8 tick
// R13 - startup count field is 8 bits, software sizes it for crystal
// R14 - counter reaching zero sets oscillator stable flag
// R15 - masked-in stable event raises processor interrupt request
// R16 - frequency count starts on main clock after next slow rising edge
// R17 - 16th slow falling edge stops counter and sets measure ready
// R18 - measured count gives main cycles in 16 slow periods; code counts from a slow rise to the 16th slow fall, 15.5 slow periods
// R19 - stable flag clear resets measurement and ready flag
`ifndef CGM_CONSTS_SVH
`define CGM_CONSTS_SVH

// register byte offsets
`define CGM_OFS_MODE      8'h00
`define CGM_OFS_PERIPH    8'h04
`define CGM_OFS_OSC       8'h08
`define CGM_OFS_FREQ      8'h0C
`define CGM_OFS_IRQ_STAT  8'h10
`define CGM_OFS_IRQ_MASK  8'h14
`define CGM_OFS_STATE     8'h18

// mode register fields
`define CGM_MODE_IDLE_BIT  0
`define CGM_MODE_SLOW_BIT  1
`define CGM_MODE_DIV2_BIT  2

// oscillator register fields
`define CGM_OSC_EN_BIT     0
`define CGM_OSC_CNT_LSB    8
`define CGM_OSC_CNT_MSB    15

// event bits in status and mask
`define CGM_EVT_STABLE     0
`define CGM_EVT_READY      1
`define CGM_EVT_W          2

// frequency register fields
`define CGM_FREQ_RDY_BIT   16
`define CGM_FREQ_W         16

// state register fields
`define CGM_STATE_MODE_LSB    0
`define CGM_STATE_MODE_MSB    3
`define CGM_STATE_STABLE_BIT  4
`define CGM_STATE_RUN_BIT     5
`define CGM_STATE_MEAS_BIT    6

// timing
`define CGM_PRESCALE_W     3
`define CGM_MEAS_PERIODS   5'h10
`define CGM_DIV2_PRESENT   1'b1

`define CGM_ALL_ONES32     32'hFFFFFFFF
`define CGM_ZERO32         32'h00000000

`endif

/* File: cgm_pkg.sv */
package cgm_pkg;

  typedef enum logic [3:0] {
    MODE_NORMAL  = 4'b0001,
    MODE_IDLE    = 4'b0010,
    MODE_SLOW    = 4'b0100,
    MODE_STANDBY = 4'b1000
  } cgm_mode_t;

endpackage

/* File: cgm_top.sv */
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "cgm_consts.svh"

module cgm_top (
  // system
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // clock sources and wake request from pins
  input  wire logic        SLOW_CLK_IN,
  input  wire logic        MAIN_CLK_IN,
  input  wire logic        IRQ_WAKE,
  // clock enables out
  output logic             PROC_CLK_EN,
  output logic             MASTER_CLK_EN,
  output logic             SLOW_CLK_EN,
  output logic             DMA_CLK_EN,
  output logic      [31:0] PERIPH_CLK_EN,
  output logic             MASTER_SRC_SLOW,
  output logic             MASTER_DIV2_EN,
  output logic             OSC_PWR_EN,
  output logic             PLL_PWR_EN,
  // interrupt
  output logic             IRQ
);

  // synchronisers: stage one feeds only stage two
  logic [1:0] slow_sync_r;
  logic [1:0] main_sync_r;
  logic [1:0] wake_sync_r;
  logic       slow_prev_r;
  logic       main_prev_r;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      slow_sync_r <= 2'h0;
      main_sync_r <= 2'h0;
      wake_sync_r <= 2'h0;
      slow_prev_r <= 1'b0;
      main_prev_r <= 1'b0;
    end else begin
      slow_sync_r <= {slow_sync_r[0], SLOW_CLK_IN};
      main_sync_r <= {main_sync_r[0], MAIN_CLK_IN};
      wake_sync_r <= {wake_sync_r[0], IRQ_WAKE};
      slow_prev_r <= slow_sync_r[1];
      main_prev_r <= main_sync_r[1];
    end
  end

  // main clock above half of CLK aliases; measure only up to about 12 MHz
  logic slow_rise;
  logic slow_fall;
  logic main_rise;
  logic wake;
  assign slow_rise = slow_sync_r[1] & ~slow_prev_r;
  assign slow_fall = ~slow_sync_r[1] & slow_prev_r;
  assign main_rise = main_sync_r[1] & ~main_prev_r;
  assign wake      = wake_sync_r[1];

  // apb decode
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == `CGM_OFS_MODE) || (a == `CGM_OFS_PERIPH) ||
                  (a == `CGM_OFS_OSC) || (a == `CGM_OFS_FREQ) ||
                  (a == `CGM_OFS_IRQ_STAT) || (a == `CGM_OFS_IRQ_MASK) ||
                  (a == `CGM_OFS_STATE);
  endfunction

  logic setup;
  logic wr_en;
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PWRITE & PREADY & ~PSLVERR;

  function automatic logic wr_to(input logic [7:0] ofs);
    wr_to = wr_en && (PADDR == ofs);
  endfunction

  // registers
  cgm_pkg::cgm_mode_t mode_r;
  logic        div2_r;
  logic [31:0] periph_r;
  logic        osc_en_r;
  logic [7:0]  osc_cnt_r;
  logic        osc_run_r;
  logic        osc_stable_r;
  logic [`CGM_PRESCALE_W-1:0] presc_r;
  logic        fm_arm_r;
  logic        fm_run_r;
  logic        fm_rdy_r;
  logic [4:0]  fm_falls_r;
  logic [`CGM_FREQ_W-1:0] fm_cnt_r;
  logic [`CGM_EVT_W-1:0]  irq_stat_r;
  logic [`CGM_EVT_W-1:0]  irq_mask_r;
  logic        stable_set;
  logic        ready_set;
  logic        tick8;

  // slow clock divided by eight
  assign tick8 = slow_rise && (presc_r == {`CGM_PRESCALE_W{1'b1}});

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      presc_r <= '0;
    end else if (slow_rise) begin
      presc_r <= presc_r + 1'b1;
    end
  end

  // oscillator enable and startup counter
  logic osc_wr;
  logic osc_wr_en;
  assign osc_wr    = wr_to(`CGM_OFS_OSC);
  assign osc_wr_en = osc_wr & PWDATA[`CGM_OSC_EN_BIT];
  assign stable_set = osc_run_r & tick8 & (osc_cnt_r == 8'h00) & ~osc_wr;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      // R10 osc off at reset
      osc_en_r     <= 1'b0;
      osc_cnt_r    <= 8'h00;
      osc_run_r    <= 1'b0;
      osc_stable_r <= 1'b0;
    end else if (osc_wr_en) begin
      // R12 load and restart
      // R13 eight bit count
      osc_en_r     <= 1'b1;
      osc_cnt_r    <= PWDATA[`CGM_OSC_CNT_MSB:`CGM_OSC_CNT_LSB];
      osc_run_r    <= 1'b1;
      osc_stable_r <= 1'b0;
    end else if (osc_wr) begin
      // R11 disable clears stable
      osc_en_r     <= 1'b0;
      osc_cnt_r    <= PWDATA[`CGM_OSC_CNT_MSB:`CGM_OSC_CNT_LSB];
      osc_run_r    <= 1'b0;
      osc_stable_r <= 1'b0;
    end else if (stable_set) begin
      // R14 zero sets stable
      osc_run_r    <= 1'b0;
      osc_stable_r <= 1'b1;
    end else if (osc_run_r && tick8) begin
      // R12 decrement per tick
      osc_cnt_r    <= osc_cnt_r - 1'b1;
    end
  end

  // frequency measurement
  assign ready_set = fm_run_r & slow_fall & (fm_falls_r == `CGM_MEAS_PERIODS - 5'h01);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fm_arm_r   <= 1'b0;
      fm_run_r   <= 1'b0;
      fm_rdy_r   <= 1'b0;
      fm_falls_r <= 5'h00;
      fm_cnt_r   <= '0;
    end else if (!osc_stable_r) begin
      // R19 fresh measurement next time
      fm_arm_r   <= 1'b0;
      fm_run_r   <= 1'b0;
      fm_rdy_r   <= 1'b0;
      fm_falls_r <= 5'h00;
      fm_cnt_r   <= '0;
    end else if (!fm_arm_r) begin
      fm_arm_r <= 1'b1;
    end else if (!fm_run_r && !fm_rdy_r) begin
      // R16 start after slow rise
      if (slow_rise) begin
        fm_run_r <= 1'b1;
      end
    end else if (fm_run_r) begin
      // R18 count main cycles
      if (main_rise) begin
        fm_cnt_r <= fm_cnt_r + 1'b1;
      end
      if (ready_set) begin
        // R17 stop on 16th fall
        fm_run_r <= 1'b0;
        fm_rdy_r <= 1'b1;
      end else if (slow_fall) begin
        fm_falls_r <= fm_falls_r + 5'h01;
      end
    end
  end

  // operating mode
  logic mode_wr;
  logic req_idle;
  logic req_slow;
  assign mode_wr  = wr_to(`CGM_OFS_MODE);
  assign req_idle = PWDATA[`CGM_MODE_IDLE_BIT];
  // leaving slow mode needs a stable oscillator
  assign req_slow = PWDATA[`CGM_MODE_SLOW_BIT] | ~osc_stable_r;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      // R03 slow mode after reset
      mode_r <= cgm_pkg::MODE_SLOW;
      div2_r <= 1'b0;
    end else begin
      if (mode_wr) begin
        // R09 build-time divider
        div2_r <= PWDATA[`CGM_MODE_DIV2_BIT] & `CGM_DIV2_PRESENT;
      end
      unique case (mode_r)
        cgm_pkg::MODE_NORMAL: begin
          if (osc_wr && !osc_wr_en) begin
            mode_r <= cgm_pkg::MODE_SLOW;
          end else if (mode_wr) begin
            // R01 enter idle
            mode_r <= req_idle ? (req_slow ? cgm_pkg::MODE_STANDBY : cgm_pkg::MODE_IDLE)
                               : (req_slow ? cgm_pkg::MODE_SLOW : cgm_pkg::MODE_NORMAL);
          end
        end
        cgm_pkg::MODE_IDLE: begin
          // R01 wake on interrupt
          if (wake) begin
            mode_r <= cgm_pkg::MODE_NORMAL;
          end else if (osc_wr && !osc_wr_en) begin
            mode_r <= cgm_pkg::MODE_STANDBY;
          end
        end
        cgm_pkg::MODE_SLOW: begin
          if (mode_wr) begin
            mode_r <= req_idle ? (req_slow ? cgm_pkg::MODE_STANDBY : cgm_pkg::MODE_IDLE)
                               : (req_slow ? cgm_pkg::MODE_SLOW : cgm_pkg::MODE_NORMAL);
          end
        end
        cgm_pkg::MODE_STANDBY: begin
          // R05 standby wakes to slow
          if (wake) begin
            mode_r <= cgm_pkg::MODE_SLOW;
          end
        end
      endcase
    end
  end

  logic in_slow;
  logic in_idle;
  assign in_slow = (mode_r == cgm_pkg::MODE_SLOW) || (mode_r == cgm_pkg::MODE_STANDBY);
  assign in_idle = (mode_r == cgm_pkg::MODE_IDLE) || (mode_r == cgm_pkg::MODE_STANDBY);

  // peripheral enables and interrupt registers
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      periph_r   <= `CGM_ZERO32;
      irq_mask_r <= '0;
    end else begin
      if (wr_to(`CGM_OFS_PERIPH)) begin
        periph_r <= PWDATA;
      end
      if (wr_to(`CGM_OFS_IRQ_MASK)) begin
        irq_mask_r <= PWDATA[`CGM_EVT_W-1:0];
      end
    end
  end

  // sticky events, a new event beats a same-cycle clear
  logic [`CGM_EVT_W-1:0] evt;
  logic [`CGM_EVT_W-1:0] clr;
  always_comb begin
    evt = '0;
    evt[`CGM_EVT_STABLE] = stable_set;
    evt[`CGM_EVT_READY]  = ready_set;
    clr = wr_to(`CGM_OFS_IRQ_STAT) ? PWDATA[`CGM_EVT_W-1:0] : '0;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~clr) | evt;
    end
  end

  // outputs, all registered
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PROC_CLK_EN     <= 1'b1;
      MASTER_CLK_EN   <= 1'b1;
      SLOW_CLK_EN     <= 1'b1;
      DMA_CLK_EN      <= 1'b1;
      PERIPH_CLK_EN   <= `CGM_ZERO32;
      MASTER_SRC_SLOW <= 1'b1;
      MASTER_DIV2_EN  <= 1'b0;
      OSC_PWR_EN      <= 1'b0;
      PLL_PWR_EN      <= 1'b0;
      IRQ             <= 1'b0;
    end else begin
      // R08 gated in idle
      PROC_CLK_EN     <= ~in_idle;
      // R07 master always on
      MASTER_CLK_EN   <= 1'b1;
      // R06 slow never off
      SLOW_CLK_EN     <= 1'b1;
      // R02 dma runs in idle
      DMA_CLK_EN      <= 1'b1;
      PERIPH_CLK_EN   <= periph_r;
      MASTER_SRC_SLOW <= in_slow;
      MASTER_DIV2_EN  <= div2_r;
      // R04 slow mode powers down pll, osc follows enable
      OSC_PWR_EN      <= osc_en_r;
      PLL_PWR_EN      <= ~in_slow;
      // R15 masked stable interrupt
      IRQ             <= |(((irq_stat_r & ~clr) | evt) & irq_mask_r);
    end
  end

  // apb answer: data captured in setup, ready in access, no wait states
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `CGM_ZERO32;
    unique case (PADDR)
      `CGM_OFS_MODE: begin
        rd_mux[`CGM_MODE_IDLE_BIT] = in_idle;
        rd_mux[`CGM_MODE_SLOW_BIT] = in_slow;
        rd_mux[`CGM_MODE_DIV2_BIT] = div2_r;
      end
      `CGM_OFS_PERIPH: rd_mux = periph_r;
      `CGM_OFS_OSC: begin
        rd_mux[`CGM_OSC_EN_BIT] = osc_en_r;
        rd_mux[`CGM_OSC_CNT_MSB:`CGM_OSC_CNT_LSB] = osc_cnt_r;
      end
      `CGM_OFS_FREQ: begin
        rd_mux[`CGM_FREQ_W-1:0]  = fm_cnt_r;
        rd_mux[`CGM_FREQ_RDY_BIT] = fm_rdy_r;
      end
      `CGM_OFS_IRQ_STAT: rd_mux[`CGM_EVT_W-1:0] = irq_stat_r;
      `CGM_OFS_IRQ_MASK: rd_mux[`CGM_EVT_W-1:0] = irq_mask_r;
      `CGM_OFS_STATE: begin
        rd_mux[`CGM_STATE_MODE_MSB:`CGM_STATE_MODE_LSB] = mode_r;
        rd_mux[`CGM_STATE_STABLE_BIT] = osc_stable_r;
        rd_mux[`CGM_STATE_RUN_BIT]    = osc_run_r;
        rd_mux[`CGM_STATE_MEAS_BIT]   = fm_run_r;
      end
      default: rd_mux = `CGM_ZERO32;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRDATA  <= `CGM_ZERO32;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & ~addr_mapped(PADDR);
      if (setup && !PWRITE) begin
        PRDATA <= rd_mux;
      end
    end
  end

endmodule // cgm_top

/* File: cgm_top_checker.sv */
`timescale 1ns/1ps
module cgm_checker (
  // apb and wake
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PWRITE,
  input wire logic       PREADY,
  input wire logic [7:0] PADDR,
  input wire logic [0:0] PWDATA,
  input wire logic       IRQ_WAKE,
  // clock enables and irq
  input wire logic       PROC_CLK_EN,
  input wire logic       MASTER_CLK_EN,
  input wire logic       SLOW_CLK_EN,
  input wire logic       DMA_CLK_EN,
  input wire logic       MASTER_SRC_SLOW,
  input wire logic       OSC_PWR_EN,
  input wire logic       PLL_PWR_EN,
  input wire logic       IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic wr_idle;
  logic wr_osc;
  assign wr_idle = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00 && PWDATA[0];
  assign wr_osc  = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h08;
  a_slow_never_off: assert property (SLOW_CLK_EN)
    else $error("slow clock enable dropped");
  a_master_always_on: assert property (MASTER_CLK_EN)
    else $error("master clock enable dropped");
  a_dma_clock_on: assert property (DMA_CLK_EN)
    else $error("dma clock enable dropped");
  a_slow_no_pll: assert property (MASTER_SRC_SLOW && $past(MASTER_SRC_SLOW) |-> !PLL_PWR_EN)
    else $error("pll powered in slow mode");
  a_osc_off_slow: assert property ($fell(OSC_PWR_EN) |-> ##[0:3] MASTER_SRC_SLOW)
    else $error("master left on main clock after oscillator off");
  a_wake_by_irq: assert property ($rose(PROC_CLK_EN) |->
    $past(IRQ_WAKE, 1) || $past(IRQ_WAKE, 2) || $past(IRQ_WAKE, 3)
    || $past(IRQ_WAKE, 4) || $past(IRQ_WAKE, 5))
    else $error("processor clock resumed without wake");
  a_idle_gate_cause: assert property ($fell(PROC_CLK_EN) |->
    $past(wr_idle, 1) || $past(wr_idle, 2) || $past(wr_idle, 3))
    else $error("processor clock stopped without idle write");
  a_irq_needs_osc: assert property ($rose(IRQ) |-> OSC_PWR_EN)
    else $error("interrupt raised with oscillator off");
  a_osc_by_write: assert property ($changed(OSC_PWR_EN) |-> $past(wr_osc, 1) || $past(wr_osc, 2))
    else $error("oscillator enable moved without write");
  c_idle_entry: cover property ($fell(PROC_CLK_EN));
  c_irq_raise: cover property ($rose(IRQ));
  c_osc_start: cover property ($rose(OSC_PWR_EN));
endmodule // cgm_checker

bind cgm_top cgm_checker u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PREADY(PREADY), .PADDR(PADDR), .PWDATA(PWDATA[0]), .IRQ_WAKE(IRQ_WAKE),
  .PROC_CLK_EN(PROC_CLK_EN), .MASTER_CLK_EN(MASTER_CLK_EN), .SLOW_CLK_EN(SLOW_CLK_EN),
  .DMA_CLK_EN(DMA_CLK_EN), .MASTER_SRC_SLOW(MASTER_SRC_SLOW), .OSC_PWR_EN(OSC_PWR_EN),
  .PLL_PWR_EN(PLL_PWR_EN), .IRQ(IRQ));

/* File: cgm_clk_src.sv */
`timescale 1ns/1ps
module cgm_clk_src (
  // oscillator control
  input  wire logic osc_en,
  // clock pins
  output logic      slow_clk,
  output logic      main_clk
);
  initial slow_clk = 1'b0;
  initial main_clk = 1'b0;
  always #320 slow_clk = ~slow_clk;
  always #80 main_clk = osc_en ? ~main_clk : 1'b0;
endmodule // cgm_clk_src

/* File: cgm_top_tb.sv */
`timescale 1ns/1ps
module cgm_top_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        irq_wake = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, periph_en, q;
  logic        pready, pslverr, slow_clk, main_clk, proc_en, master_en, slow_en, dma_en;
  logic        src_slow, div2_en, osc_en, pll_en, irq, e;
  int          mismatches = 0;
  int          checks = 0;
  always #20 clk = ~clk;
  cgm_top dut (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SLOW_CLK_IN(slow_clk), .MAIN_CLK_IN(main_clk), .IRQ_WAKE(irq_wake), .PROC_CLK_EN(proc_en),
    .MASTER_CLK_EN(master_en), .SLOW_CLK_EN(slow_en), .DMA_CLK_EN(dma_en),
    .PERIPH_CLK_EN(periph_en), .MASTER_SRC_SLOW(src_slow), .MASTER_DIV2_EN(div2_en),
    .OSC_PWR_EN(osc_en), .PLL_PWR_EN(pll_en), .IRQ(irq));
  cgm_clk_src u_src (.osc_en(osc_en), .slow_clk(slow_clk), .main_clk(main_clk));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer, result left in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic t_reset();
    chk({24'h0, proc_en, master_en, slow_en, dma_en, src_slow, osc_en, pll_en, irq},
        32'h000000F8);
    apb(1'b0, 8'h18, 32'h0);
    chk(q & 32'h0000001F, 32'h00000004);
  endtask
  task automatic t_startup();
    int n;
    apb(1'b1, 8'h14, 32'h00000003);
    apb(1'b1, 8'h08, 32'h00000201);
    apb(1'b0, 8'h18, 32'h0);
    chk(q & 32'h00000010, 32'h00000000);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
    chk({31'h0, n >= 150 && n <= 450}, 32'h00000001);
    apb(1'b0, 8'h18, 32'h0);
    chk(q & 32'h00000010, 32'h00000010);
  endtask
  task automatic t_freq();
    int n;
    n = 0;
    q = 32'h0;
    while (q[16] !== 1'b1 && n < 300) begin apb(1'b0, 8'h0C, 32'h0); n++; end
    chk({31'h0, q[15:0] >= 16'h003A && q[15:0] <= 16'h0044}, 32'h00000001);
    apb(1'b0, 8'h10, 32'h0);
    chk(q & 32'h00000003, 32'h00000003);
    apb(1'b1, 8'h10, 32'h00000003);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h00000000);
  endtask
  task automatic wake();
    irq_wake <= 1'b1;
    repeat (8) @(posedge clk);
    irq_wake <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_modes();
    apb(1'b1, 8'h00, 32'h00000000);
    repeat (3) @(posedge clk);
    chk({29'h0, proc_en, src_slow, pll_en}, 32'h00000005);
    apb(1'b1, 8'h00, 32'h00000001);
    repeat (3) @(posedge clk);
    chk({29'h0, proc_en, dma_en, master_en}, 32'h00000003);
    apb(1'b0, 8'h18, 32'h0);
    chk(q & 32'h0000000F, 32'h00000002);
    wake();
    chk({31'h0, proc_en}, 32'h00000001);
    apb(1'b1, 8'h00, 32'h00000002);
    apb(1'b1, 8'h00, 32'h00000003);
    repeat (3) @(posedge clk);
    chk({30'h0, proc_en, src_slow}, 32'h00000001);
    wake();
    apb(1'b0, 8'h18, 32'h0);
    chk(q & 32'h0000000F, 32'h00000004);
    apb(1'b1, 8'h00, 32'h00000004);
    apb(1'b1, 8'h04, 32'hA5A50F0F);
    repeat (2) @(posedge clk);
    chk({31'h0, div2_en}, 32'h00000001);
    chk(periph_en, 32'hA5A50F0F);
    apb(1'b0, 8'h40, 32'h0);
    chk({q[30:0], e}, 32'h00000001);
  endtask
  task automatic t_osc_off();
    apb(1'b1, 8'h00, 32'h00000001);
    apb(1'b1, 8'h08, 32'h00000000);
    repeat (3) @(posedge clk);
    chk({30'h0, proc_en, src_slow}, 32'h00000001);
    apb(1'b0, 8'h18, 32'h0);
    chk(q & 32'h0000001F, 32'h00000008);
    wake();
    apb(1'b1, 8'h00, 32'h00000000);
    apb(1'b0, 8'h18, 32'h0);
    chk(q & 32'h0000001F, 32'h00000004);
    apb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h00000000);
  endtask
  task automatic t_rerun();
    apb(1'b1, 8'h08, 32'h00000501);
    repeat (2) @(posedge clk);
    chk({31'h0, osc_en}, 32'h00000001);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({24'h0, proc_en, master_en, slow_en, dma_en, src_slow, osc_en, pll_en, irq},
        32'h000000F8);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h00000000);
    apb(1'b0, 8'h18, 32'h0);
    chk(q & 32'h0000001F, 32'h00000004);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_startup();
    t_freq();
    t_modes();
    t_osc_off();
    t_rerun();
    give_verdict();
  end
  initial begin
    #1000000;
    mismatches++;
    give_verdict();
  end
endmodule // cgm_top_tb
